// File: design/autoneg_np_regs.sv
// Partner next page, ability mirror and forced mode register bank
//
// Notes on behaviour
// RULE1 - Reading the low partner word captures the middle and upper words at once.
// RULE2 - Middle and upper partner words read back the values caught at the last low read.
// RULE3 - Bit 13 of the low partner word shows the partner page encoding, 1 for message.
// RULE4 - Bits 10 to 0 of the low partner word carry the code, with 1, 5 and 6 recognised.
// RULE5 - Bits 15, 14, 12 and 11 show request, acknowledge, acknowledge-2 and toggle.
// RULE6 - Middle and upper partner words are read-only 16-bit raw fields resetting to zero.
// RULE7 - Local long reach advertisement aliases the base page bit and resets to one.
// RULE8 - Local energy saving advertisement is a read-only mirror of the base page bit.
// RULE9 - Local high swing bits alias the base page bits and reset from a strap pin.
// RULE10 - Partner ability bits 15 to 12 mirror the received long reach abilities.
// RULE11 - Partner ability bits 7 and 6 mirror short reach full and half duplex.
// RULE12 - Forced link mode engages only with negotiation off and the forced bit set.
// RULE13 - The forced bit is bit 0, writable, resets to zero, bits 15 to 1 reserved.
// RULE14 - Reserved bits read as zero and ignore writes.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module autoneg_np_regs
	import autoneg_np_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [ADDR_W-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic partnerMorePagesFlag,
	input wire logic partnerPageAck,
	input wire logic partnerPageEncoding,
	input wire logic partnerComplyAck,
	input wire logic partnerPageToggle,
	input wire logic [10:0] partnerMessageCode,
	input wire logic [15:0] partnerRawFieldOne,
	input wire logic [15:0] partnerRawFieldTwo,
	input wire logic partnerLongReachAbility,
	input wire logic partnerEnergySavingAbility,
	input wire logic partnerHighSwingAbility,
	input wire logic partnerHighSwingRequest,
	input wire logic partnerShortReachFullDuplex,
	input wire logic partnerShortReachHalfDuplex,
	input wire logic baseEnergySavingAdvert,
	input wire logic baseAdvertWrite,
	input wire logic baseLongReachAdvertIn,
	input wire logic baseHighSwingAbilityAdvertIn,
	input wire logic baseHighSwingRequestAdvertIn,
	input wire logic highSwingStrap,
	input wire logic negotiationEnable,
	output logic baseLongReachAdvert,
	output logic baseHighSwingAbilityAdvert,
	output logic baseHighSwingRequestAdvert,
	output logic partnerCodeKnown,
	output logic forcedLinkMode
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic strapMeta;
		logic strapSync;
		logic [1:0] strapCnt;
		logic strapDone;
		logic longReach;
		logic highSwingAbl;
		logic highSwingReq;
		logic forced;
	} bank_t;

	bank_t bank_reg;
	bank_t bank_next;

	logic regWrite;
	logic [ADDR_W-1:0] regWrAddr;
	logic [31:0] regWrData;
	logic [3:0] regWrStrb;
	logic regWrOk;
	logic regRead;
	logic [ADDR_W-1:0] regRdAddr;
	logic [31:0] regRdData;
	logic regRdOk;
	logic snapTake;
	logic [15:0] heldMid;
	logic [15:0] heldHigh;
	logic [15:0] liveLow;
	logic [15:0] rdWord;

	// ------------------------------------------------------------------
	// Bus slave and snapshot holding registers
	// ------------------------------------------------------------------
	axil_reg_port #(.AddrWidth(ADDR_W)) busPort (
		.clk(clk),
		.rst(rst),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.regWrite(regWrite),
		.regWrAddr(regWrAddr),
		.regWrData(regWrData),
		.regWrStrb(regWrStrb),
		.regWrOk(regWrOk),
		.regRead(regRead),
		.regRdAddr(regRdAddr),
		.regRdData(regRdData),
		.regRdOk(regRdOk)
	);

	// Capture happens on the same edge that accepts the low-word read
	assign snapTake = regRead && (regRdAddr == ADDR_LP_LOW); // RULE1

	page_snapshot #(.Width(16)) snapshot (
		.clk(clk),
		.rst(rst),
		.capture(snapTake),
		.liveMid(partnerRawFieldOne),
		.liveHigh(partnerRawFieldTwo),
		.heldMid(heldMid),
		.heldHigh(heldHigh)
	);

	// ------------------------------------------------------------------
	// Read side
	// ------------------------------------------------------------------
	// Low partner word assembled live from the negotiation engine
	always_comb begin
		liveLow = RST_WORD;
		liveLow[NP_MORE_BIT] = partnerMorePagesFlag; // RULE5
		liveLow[NP_ACK_BIT] = partnerPageAck; // RULE5
		liveLow[NP_ENC_BIT] = partnerPageEncoding; // RULE3
		liveLow[NP_ACK2_BIT] = partnerComplyAck; // RULE5
		liveLow[NP_TOGGLE_BIT] = partnerPageToggle; // RULE5
		liveLow[NP_CODE_MSB:0] = partnerMessageCode; // RULE4
	end

	// Read mux; bits not placed stay zero, unmapped answers an error
	always_comb begin
		rdWord = RST_WORD; // RULE14
		regRdOk = 1'b1;
		case (regRdAddr)
			ADDR_LP_LOW: begin
				rdWord = liveLow;
			end
			ADDR_LP_MID: begin
				rdWord = heldMid; // RULE2 RULE6
			end
			ADDR_LP_HIGH: begin
				rdWord = heldHigh; // RULE2 RULE6
			end
			ADDR_LOC_ADV: begin
				rdWord[ADV_LONG_BIT] = bank_reg.longReach; // RULE7
				rdWord[ADV_EEE_BIT] = baseEnergySavingAdvert; // RULE8
				rdWord[ADV_HS_ABL_BIT] = bank_reg.highSwingAbl; // RULE9
				rdWord[ADV_HS_REQ_BIT] = bank_reg.highSwingReq; // RULE9
			end
			ADDR_LP_ABIL: begin
				rdWord[LPA_LONG_BIT] = partnerLongReachAbility; // RULE10
				rdWord[LPA_EEE_BIT] = partnerEnergySavingAbility; // RULE10
				rdWord[LPA_HS_ABL_BIT] = partnerHighSwingAbility; // RULE10
				rdWord[LPA_HS_REQ_BIT] = partnerHighSwingRequest; // RULE10
				rdWord[LPA_FD_BIT] = partnerShortReachFullDuplex; // RULE11
				rdWord[LPA_HD_BIT] = partnerShortReachHalfDuplex; // RULE11
			end
			ADDR_FORCE: begin
				rdWord[FORCE_BIT] = bank_reg.forced; // RULE13
			end
			default: begin
				regRdOk = 1'b0;
			end
		endcase
	end

	assign regRdData = {16'h0000, rdWord};

	// Writes to read-only words are accepted and dropped
	always_comb begin
		case (regWrAddr)
			ADDR_LP_LOW, ADDR_LP_MID, ADDR_LP_HIGH, ADDR_LOC_ADV, ADDR_LP_ABIL, ADDR_FORCE: begin
				regWrOk = 1'b1;
			end
			default: begin
				regWrOk = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Write side, strap capture and aliasing
	// ------------------------------------------------------------------
	// Strap waits for the synchroniser to fill before it is trusted;
	// a later bus or base page write then overrides the strap value.
	always_comb begin
		bank_next = bank_reg;
		bank_next.strapMeta = highSwingStrap;
		bank_next.strapSync = bank_reg.strapMeta;
		if (!bank_reg.strapDone) begin
			if (bank_reg.strapCnt == STRAP_SETTLE) begin
				bank_next.strapDone = 1'b1;
				bank_next.highSwingAbl = bank_reg.strapSync; // RULE9
				bank_next.highSwingReq = bank_reg.strapSync; // RULE9
			end else begin
				bank_next.strapCnt = bank_reg.strapCnt + 2'h1;
			end
		end
		// Base page side writes land in the same flops
		if (baseAdvertWrite) begin
			bank_next.longReach = baseLongReachAdvertIn; // RULE7
			bank_next.highSwingAbl = baseHighSwingAbilityAdvertIn; // RULE9
			bank_next.highSwingReq = baseHighSwingRequestAdvertIn; // RULE9
		end
		// Bus write; advert bits sit in the upper byte lane of the word
		if (regWrite && (regWrAddr == ADDR_LOC_ADV) && regWrStrb[1]) begin
			bank_next.longReach = regWrData[ADV_LONG_BIT]; // RULE7
			bank_next.highSwingAbl = regWrData[ADV_HS_ABL_BIT]; // RULE9
			bank_next.highSwingReq = regWrData[ADV_HS_REQ_BIT]; // RULE9
		end
		if (regWrite && (regWrAddr == ADDR_FORCE) && regWrStrb[0]) begin
			bank_next.forced = regWrData[FORCE_BIT]; // RULE13
		end
	end

	// Registered bank state
	always_ff @(posedge clk) begin
		if (rst) begin
			bank_reg <= '0;
			bank_reg.longReach <= RST_LONG_REACH; // RULE7
			bank_reg.forced <= RST_FORCED; // RULE13
		end else begin
			bank_reg <= bank_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs to the base page and link control
	// ------------------------------------------------------------------
	assign baseLongReachAdvert = bank_reg.longReach; // RULE7
	assign baseHighSwingAbilityAdvert = bank_reg.highSwingAbl; // RULE9
	assign baseHighSwingRequestAdvert = bank_reg.highSwingReq; // RULE9
	assign forcedLinkMode = !negotiationEnable && bank_reg.forced; // RULE12
	assign partnerCodeKnown = partnerPageEncoding &&
		((partnerMessageCode == MSG_NULL) || (partnerMessageCode == MSG_OUI_TAG) ||
		(partnerMessageCode == MSG_DEVICE_TAG)); // RULE4

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence lowReadTaken;
		regRead && (regRdAddr == ADDR_LP_LOW);
	endsequence

	sequence midReadTaken;
		regRead && (regRdAddr == ADDR_LP_MID);
	endsequence

	snap_capture_a: assert property (lowReadTaken |=> // RULE1
		(heldMid == $past(partnerRawFieldOne)) && (heldHigh == $past(partnerRawFieldTwo)))
		else $error("snapshot not taken on low word read");

	held_stable_a: assert property (!snapTake |=> $stable(heldMid) && $stable(heldHigh)) // RULE2
		else $error("held partner words changed without a low read");

	mid_read_held_a: assert property (midReadTaken |=> // RULE2
		s_axil_rvalid && (s_axil_rdata == {16'h0000, $past(heldMid)}))
		else $error("middle word read did not return held value");

	low_fields_a: assert property (lowReadTaken |=> // RULE5
		(s_axil_rdata[NP_MORE_BIT] == $past(partnerMorePagesFlag)) &&
		(s_axil_rdata[NP_ACK_BIT] == $past(partnerPageAck)) &&
		(s_axil_rdata[NP_ACK2_BIT] == $past(partnerComplyAck)) &&
		(s_axil_rdata[NP_TOGGLE_BIT] == $past(partnerPageToggle)))
		else $error("low word flag bits wrong");

	low_code_a: assert property (lowReadTaken |=> // RULE4
		(s_axil_rdata[NP_CODE_MSB:0] == $past(partnerMessageCode)) &&
		(s_axil_rdata[NP_ENC_BIT] == $past(partnerPageEncoding)))
		else $error("low word code or encoding wrong");

	strap_load_a: assert property ($rose(bank_reg.strapDone) && !$past(baseAdvertWrite) && // RULE9
		!$past(regWrite) |-> (bank_reg.highSwingAbl == $past(bank_reg.strapSync)))
		else $error("strap value not loaded");

	adv_alias_a: assert property (baseAdvertWrite && !regWrite |=> // RULE7
		(baseLongReachAdvert == $past(baseLongReachAdvertIn)) &&
		(baseHighSwingAbilityAdvert == $past(baseHighSwingAbilityAdvertIn)) &&
		(baseHighSwingRequestAdvert == $past(baseHighSwingRequestAdvertIn)))
		else $error("base page write did not reach advert bits");

	forced_gate_a: assert property (negotiationEnable |-> !forcedLinkMode) // RULE12
		else $error("forced mode active while negotiating");

	forced_write_a: assert property (regWrite && (regWrAddr == ADDR_FORCE) && regWrStrb[0] // RULE13
		|=> (bank_reg.forced == $past(regWrData[FORCE_BIT])) && s_axil_bvalid)
		else $error("forced bit write lost");

	reserved_zero_a: assert property (regRead && (regRdAddr == ADDR_LOC_ADV) |=> // RULE14
		(s_axil_rdata[11:0] == 12'h000) && (s_axil_rdata[31:16] == 16'h0000))
		else $error("reserved advert bits not zero");

	ability_mirror_a: assert property (regRead && (regRdAddr == ADDR_LP_ABIL) |=> // RULE11
		(s_axil_rdata[LPA_FD_BIT] == $past(partnerShortReachFullDuplex)) &&
		(s_axil_rdata[LPA_HD_BIT] == $past(partnerShortReachHalfDuplex)) &&
		(s_axil_rdata[LPA_LONG_BIT] == $past(partnerLongReachAbility)))
		else $error("partner ability mirror wrong");

endmodule : autoneg_np_regs
`default_nettype wire

// File: design/autoneg_np_pkg.sv
// Register map, field layout, reset values and timing for the negotiation bank
package autoneg_np_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses (byte address is four times index)
	// ------------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_LP_LOW = 16'h020B;
	localparam logic [15:0] IDX_LP_MID = 16'h020C;
	localparam logic [15:0] IDX_LP_HIGH = 16'h020D;
	localparam logic [15:0] IDX_LOC_ADV = 16'h020E;
	localparam logic [15:0] IDX_LP_ABIL = 16'h020F;
	localparam logic [15:0] IDX_FORCE = 16'h8000;
	localparam logic [ADDR_W-1:0] ADDR_LP_LOW = {IDX_LP_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LP_MID = {IDX_LP_MID, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LP_HIGH = {IDX_LP_HIGH, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LOC_ADV = {IDX_LOC_ADV, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LP_ABIL = {IDX_LP_ABIL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FORCE = {IDX_FORCE, 2'h0};

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int NP_MORE_BIT = 15;
	localparam int NP_ACK_BIT = 14;
	localparam int NP_ENC_BIT = 13;
	localparam int NP_ACK2_BIT = 12;
	localparam int NP_TOGGLE_BIT = 11;
	localparam int NP_CODE_MSB = 10;
	localparam int ADV_LONG_BIT = 15;
	localparam int ADV_EEE_BIT = 14;
	localparam int ADV_HS_ABL_BIT = 13;
	localparam int ADV_HS_REQ_BIT = 12;
	localparam int LPA_LONG_BIT = 15;
	localparam int LPA_EEE_BIT = 14;
	localparam int LPA_HS_ABL_BIT = 13;
	localparam int LPA_HS_REQ_BIT = 12;
	localparam int LPA_FD_BIT = 7;
	localparam int LPA_HD_BIT = 6;
	localparam int FORCE_BIT = 0;

	// ------------------------------------------------------------------
	// Reset values, message codes, bus answers, timing
	// ------------------------------------------------------------------
	localparam logic RST_LONG_REACH = 1'b1;
	localparam logic RST_FORCED = 1'b0;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [10:0] MSG_NULL = 11'h001;
	localparam logic [10:0] MSG_OUI_TAG = 11'h005;
	localparam logic [10:0] MSG_DEVICE_TAG = 11'h006;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage : autoneg_np_pkg

// File: design/page_snapshot.sv
// Holding registers for the middle and upper partner next page words
`timescale 1ns/1ps
`default_nettype none
module page_snapshot
	import autoneg_np_pkg::*;
#(
	parameter int Width = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic capture,
	input wire logic [Width-1:0] liveMid,
	input wire logic [Width-1:0] liveHigh,
	output logic [Width-1:0] heldMid,
	output logic [Width-1:0] heldHigh
);
	typedef struct packed {
		logic [Width-1:0] mid;
		logic [Width-1:0] high;
	} snap_t;

	snap_t snap_reg;
	snap_t snap_next;

	// Both words are taken in one edge so the pair always belongs together
	always_comb begin
		snap_next = snap_reg;
		if (capture) begin
			snap_next.mid = liveMid;
			snap_next.high = liveHigh;
		end
	end

	// Registered holding state
	always_ff @(posedge clk) begin
		if (rst) begin
			snap_reg <= '0;
		end else begin
			snap_reg <= snap_next;
		end
	end

	assign heldMid = snap_reg.mid;
	assign heldHigh = snap_reg.high;
endmodule : page_snapshot
`default_nettype wire

// File: design/axil_reg_port.sv
// AXI4-Lite slave turning bus transfers into single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port
	import autoneg_np_pkg::*;
#(
	parameter int AddrWidth = ADDR_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [AddrWidth-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [AddrWidth-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	output logic regWrite,
	output logic [AddrWidth-1:0] regWrAddr,
	output logic [31:0] regWrData,
	output logic [3:0] regWrStrb,
	input wire logic regWrOk,
	output logic regRead,
	output logic [AddrWidth-1:0] regRdAddr,
	input wire logic [31:0] regRdData,
	input wire logic regRdOk
);
	typedef struct packed {
		logic awHave;
		logic [AddrWidth-1:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} port_t;

	port_t port_reg;
	port_t port_next;

	// Address and data are parked separately, so either may come first
	assign s_axil_awready = !port_reg.awHave && !port_reg.bValid;
	assign s_axil_wready = !port_reg.wHave && !port_reg.bValid;
	assign s_axil_arready = !port_reg.rValid;
	assign regWrite = port_reg.awHave && port_reg.wHave && !port_reg.bValid;
	assign regWrAddr = port_reg.awAddr;
	assign regWrData = port_reg.wData;
	assign regWrStrb = port_reg.wStrb;
	assign regRead = s_axil_arvalid && s_axil_arready;
	assign regRdAddr = s_axil_araddr;

	// Channel bookkeeping
	always_comb begin
		port_next = port_reg;
		if (s_axil_awvalid && s_axil_awready) begin
			port_next.awHave = 1'b1;
			port_next.awAddr = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			port_next.wHave = 1'b1;
			port_next.wData = s_axil_wdata;
			port_next.wStrb = s_axil_wstrb;
		end
		if (regWrite) begin
			port_next.awHave = 1'b0;
			port_next.wHave = 1'b0;
			port_next.bValid = 1'b1;
			port_next.bResp = regWrOk ? RESP_OKAY : RESP_SLVERR;
		end else if (port_reg.bValid && s_axil_bready) begin
			port_next.bValid = 1'b0;
		end
		if (regRead) begin
			port_next.rValid = 1'b1;
			port_next.rData = regRdData;
			port_next.rResp = regRdOk ? RESP_OKAY : RESP_SLVERR;
		end else if (port_reg.rValid && s_axil_rready) begin
			port_next.rValid = 1'b0;
		end
	end

	// Registered channel state
	always_ff @(posedge clk) begin
		if (rst) begin
			port_reg <= '0;
		end else begin
			port_reg <= port_next;
		end
	end

	assign s_axil_bvalid = port_reg.bValid;
	assign s_axil_bresp = port_reg.bResp;
	assign s_axil_rvalid = port_reg.rValid;
	assign s_axil_rdata = port_reg.rData;
	assign s_axil_rresp = port_reg.rResp;
endmodule : axil_reg_port
`default_nettype wire

// File: sim/autoneg_np_regs_tb.sv
// Self-checking bench for the negotiation register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin nFail++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module autoneg_np_regs_tb
	import autoneg_np_pkg::*;
;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] awAddr = '0, arAddr = '0;
	logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, bReady = 1'b1, rReady = 1'b1;
	logic [31:0] wData = 32'h0;
	logic [3:0] wStrb = 4'hF;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp;
	logic [31:0] rData;
	logic npMore = 1'b0, npAck = 1'b0, npEnc = 1'b0, npAck2 = 1'b0, npTog = 1'b0;
	logic [10:0] npCode = 11'h0;
	logic [15:0] rawOne = 16'h0, rawTwo = 16'h0, m, h;
	logic [5:0] lpAbil = 6'h0;
	logic baseEee = 1'b0, baseWr = 1'b0, bLongIn = 1'b0, bAblIn = 1'b0, bReqIn = 1'b0;
	logic strap = 1'b0, negEn = 1'b1;
	logic baseLong, baseAbl, baseReq, codeKnown, forced;
	logic advLong, advAbl, advReq;
	logic [31:0] d;
	logic [10:0] codes [6] = '{11'h001, 11'h005, 11'h006, 11'h000, 11'h002, 11'h7FF};
	int nFail = 0, checkCount = 0, cycles = 0, seed = 32'h32D05320;

	autoneg_np_regs autoneg_np_regs_inst (.clk(clk), .rst(rst),
		.s_axil_awaddr(awAddr), .s_axil_awvalid(awValid), .s_axil_awready(awReady),
		.s_axil_wdata(wData), .s_axil_wstrb(wStrb), .s_axil_wvalid(wValid),
		.s_axil_wready(wReady), .s_axil_bresp(bResp), .s_axil_bvalid(bValid),
		.s_axil_bready(bReady), .s_axil_araddr(arAddr), .s_axil_arvalid(arValid),
		.s_axil_arready(arReady), .s_axil_rdata(rData), .s_axil_rresp(rResp),
		.s_axil_rvalid(rValid), .s_axil_rready(rReady),
		.partnerMorePagesFlag(npMore), .partnerPageAck(npAck), .partnerPageEncoding(npEnc),
		.partnerComplyAck(npAck2), .partnerPageToggle(npTog), .partnerMessageCode(npCode),
		.partnerRawFieldOne(rawOne), .partnerRawFieldTwo(rawTwo),
		.partnerLongReachAbility(lpAbil[5]), .partnerEnergySavingAbility(lpAbil[4]),
		.partnerHighSwingAbility(lpAbil[3]), .partnerHighSwingRequest(lpAbil[2]),
		.partnerShortReachFullDuplex(lpAbil[1]), .partnerShortReachHalfDuplex(lpAbil[0]),
		.baseEnergySavingAdvert(baseEee), .baseAdvertWrite(baseWr),
		.baseLongReachAdvertIn(bLongIn), .baseHighSwingAbilityAdvertIn(bAblIn),
		.baseHighSwingRequestAdvertIn(bReqIn), .highSwingStrap(strap),
		.negotiationEnable(negEn), .baseLongReachAdvert(baseLong),
		.baseHighSwingAbilityAdvert(baseAbl), .baseHighSwingRequestAdvert(baseReq),
		.partnerCodeKnown(codeKnown), .forcedLinkMode(forced));

	// Clock and hang guard; a run past the ceiling counts as a mismatch
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nFail++;
			testDone();
		end
	end

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic logic [31:0] lowWord();
		return {16'h0, npMore, npAck, npEnc, npAck2, npTog, npCode};
	endfunction : lowWord
	function automatic logic [31:0] advWord();
		return {16'h0, advLong, baseEee, advAbl, advReq, 12'h0};
	endfunction : advWord
	function automatic logic [31:0] abilWord();
		return {16'h0, lpAbil[5:2], 4'h0, lpAbil[1:0], 6'h0};
	endfunction : abilWord

	// ----------------------------------------
	// Bus tasks; ready is looked at mid-cycle so the handshake edge is known
	// ----------------------------------------
	task automatic wrChk(input logic [ADDR_W-1:0] a, input logic [31:0] dt,
		input logic [3:0] s, input logic [1:0] er);
		logic ta, tw, da, dw, b;
		da = 1'b0;
		dw = 1'b0;
		b = 1'b0;
		@(posedge clk);
		awAddr <= a;
		wData <= dt;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		while (!(da && dw)) begin
			@(negedge clk);
			ta = awValid && awReady;
			tw = wValid && wReady;
			@(posedge clk);
			if (ta) begin
				awValid <= 1'b0;
				da = 1'b1;
			end
			if (tw) begin
				wValid <= 1'b0;
				dw = 1'b1;
			end
		end
		while (!b) begin
			@(negedge clk);
			b = bValid;
			if (b) `CHK(bResp, er)
			@(posedge clk);
		end
	endtask : wrChk

	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic t;
		t = 1'b0;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		while (!t) begin
			@(negedge clk);
			t = arReady;
			@(posedge clk);
		end
		arValid <= 1'b0;
		t = 1'b0;
		while (!t) begin
			@(negedge clk);
			t = rValid;
			if (t) `CHK(rData, e)
			if (t) `CHK(rResp, er)
			@(posedge clk);
		end
	endtask : rdChk

	task automatic testDone();
		$display("checks=%0d mismatches=%0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : testDone

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		@(posedge clk);
		strap <= 1'($random(seed));
		rawOne <= 16'($random(seed));
		rawTwo <= 16'($random(seed));
		repeat (15) @(posedge clk);
		rst <= 1'b0;
		// Strap lands a few edges after release, so wait it out
		repeat (6) @(posedge clk);
		advLong = 1'b1;
		advAbl = strap;
		advReq = strap;
		`CHK(baseLong, 1'b1)
		rdChk(ADDR_LP_MID, 32'h0, RESP_OKAY);
		rdChk(ADDR_LP_HIGH, 32'h0, RESP_OKAY);
		rdChk(ADDR_LP_LOW, 32'h0, RESP_OKAY);
		rdChk(ADDR_LOC_ADV, advWord(), RESP_OKAY);
		rdChk(ADDR_LP_ABIL, 32'h0, RESP_OKAY);
		rdChk(ADDR_FORCE, 32'h0, RESP_OKAY);
		rdChk(ADDR_FORCE + 18'h4, 32'h0, RESP_SLVERR);
		$display("test reset values done");
		// Random pages: middle and upper words must hold the low-read snapshot
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{npMore, npAck, npEnc, npAck2, npTog} <= 5'($random(seed));
			npCode <= 11'($random(seed));
			{rawOne, rawTwo} <= 32'($random(seed));
			{lpAbil, baseEee} <= 7'($random(seed));
			@(negedge clk);
			m = rawOne;
			h = rawTwo;
			rdChk(ADDR_LP_LOW, lowWord(), RESP_OKAY);
			rawOne <= ~m;
			rawTwo <= ~h;
			rdChk(ADDR_LP_MID, {16'h0, m}, RESP_OKAY);
			rdChk(ADDR_LP_HIGH, {16'h0, h}, RESP_OKAY);
			rdChk(ADDR_LP_ABIL, abilWord(), RESP_OKAY);
			rdChk(ADDR_LOC_ADV, advWord(), RESP_OKAY);
		end
		$display("test snapshot done");
		// Every recognised code and some outsiders, with both encodings
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			npEnc <= i[0];
			npCode <= codes[i / 2];
			@(negedge clk);
			`CHK(codeKnown, npEnc && (npCode inside {MSG_NULL, MSG_OUI_TAG, MSG_DEVICE_TAG}))
			rdChk(ADDR_LP_LOW, lowWord(), RESP_OKAY);
		end
		$display("test codes done");
		// Advert writes; the last one lacks the strobe that covers the bits
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			wrChk(ADDR_LOC_ADV, d, (i == 3) ? 4'h1 : 4'hF, RESP_OKAY);
			if (i != 3) {advLong, advAbl, advReq} = {d[15], d[13], d[12]};
			rdChk(ADDR_LOC_ADV, advWord(), RESP_OKAY);
			`CHK({baseLong, baseAbl, baseReq}, {advLong, advAbl, advReq})
		end
		{advLong, advAbl, advReq} = ~{advLong, advAbl, advReq};
		@(posedge clk);
		baseWr <= 1'b1;
		{bLongIn, bAblIn, bReqIn} <= {advLong, advAbl, advReq};
		@(posedge clk);
		baseWr <= 1'b0;
		rdChk(ADDR_LOC_ADV, advWord(), RESP_OKAY);
		$display("test advert done");
		// Forced mode only counts while negotiation is off
		wrChk(ADDR_FORCE, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
		rdChk(ADDR_FORCE, 32'h1, RESP_OKAY);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			negEn <= i[0];
			@(negedge clk);
			`CHK(forced, !negEn)
		end
		@(posedge clk);
		negEn <= 1'b0;
		wrChk(ADDR_FORCE, 32'h0, 4'hF, RESP_OKAY);
		`CHK(forced, 1'b0)
		m = rawOne;
		wrChk(ADDR_LP_MID, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
		rdChk(ADDR_LP_MID, {16'h0, m}, RESP_OKAY);
		wrChk(ADDR_FORCE + 18'h4, 32'h1, 4'hF, RESP_SLVERR);
		$display("test forced done");
		testDone();
	end
endmodule : autoneg_np_regs_tb
`undef CHK
`default_nettype wire
